// ===== hdl/lcdscu_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; depth must be a power of two.
`timescale 1ns/1ps
`default_nettype none
module lcdscu_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(D);
    // ==========================================================
    // Elaboration check: wrap logic relies on power-of-two depth
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
        $error("lcdscu_fifo depth must be a power of two");
    end
    logic [W-1:0] mem_r [D]; // Storage
    logic [AW-1:0] wp_r; // Write index
    logic [AW-1:0] rp_r; // Read index
    logic [AW:0] cnt_r; // Fill level
    logic push;
    logic pop;
    assign o_in_ready = cnt_r != (AW+1)'(D);
    assign o_out_valid = cnt_r != '0;
    assign o_out_data = mem_r[rp_r];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    // ==========================================================
    // Pointers and level
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop) rp_r <= rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    // Storage has no reset; empty flag hides stale entries
    always_ff @(posedge i_ref_clk) begin
        if (push) mem_r[wp_r] <= i_in_data;
    end
    // Level moves by exactly one on a lone push
    fifo_count_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        push && !pop |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("fifo level did not rise on push");
endmodule
`default_nettype wire

// ===== hdl/lcdscu_pkg.sv
// Shared constants of the LCD serial command unit: address, opcodes,
// field positions, reset values and frame timing.
// Assumes a single 200 MHz reference clock.
`default_nettype none
package lcdscu_pkg;
    // ==========================================================
    // Bus and display RAM
    localparam logic [7:0] SLAVE_ADDR = 8'h7C;
    localparam int RAM_WORDS = 50;
    localparam int NUM_COM = 4;
    localparam logic [5:0] LAST_ADDR = 6'h31;
    localparam logic [5:0] ADDR_RST = 6'h00;
    // ==========================================================
    // Command patterns on bits 6..0 (bit 7 is the continue flag);
    // x marks a field or don't-care bit, matched with wildcard equality
    localparam int CONT_BIT = 7;
    localparam logic [6:0] PAT_MODE = 7'b100_xxxx;
    localparam logic [6:0] PAT_ADDRESS_SET_CMD = 7'b00x_xxxx;
    localparam logic [6:0] PAT_DISPLAY_CONTROL_CMD = 7'b01x_xxxx;
    localparam logic [6:0] PAT_OPERATION_CONFIG_CMD = 7'b110_1xxx;
    localparam logic [6:0] PAT_BLINK = 7'b111_0xxx;
    // Field positions
    localparam int MODE_ON_BIT = 3;
    localparam int MODE_BIAS_BIT = 2;
    localparam int DISC_FR_LSB = 3;
    localparam int DISC_WAVE_BIT = 2;
    localparam int DISC_SR_LSB = 0;
    localparam int IC_MSB_BIT = 2;
    localparam int IC_RST_BIT = 1;
    localparam int IC_EXT_BIT = 0;
    localparam int BLINK_LSB = 0;
    // Reset values
    localparam logic [1:0] SR_RST = 2'h2;
    localparam logic [1:0] FR_RST = 2'h0;
    localparam logic [1:0] BLINK_RST = 2'h0;
    // ==========================================================
    // Frame timing: one common slot is a quarter frame
    localparam int CLK_HZ = 200_000_000;
    localparam int FR_NORM_HZ = 80;
    localparam int FR_PS1_HZ = 71;
    localparam int FR_PS2_HZ = 64;
    localparam int FR_PS3_HZ = 50;
    localparam int SLOT_NORM_CYC = CLK_HZ / (FR_NORM_HZ * NUM_COM);
    localparam int SLOT_PS1_CYC = CLK_HZ / (FR_PS1_HZ * NUM_COM);
    localparam int SLOT_PS2_CYC = CLK_HZ / (FR_PS2_HZ * NUM_COM);
    localparam int SLOT_PS3_CYC = CLK_HZ / (FR_PS3_HZ * NUM_COM);
    // Blink half periods in frames at nominal rate: 0.5, 1, 2 Hz
    localparam logic [7:0] BLINK_HALF_05 = 8'(FR_NORM_HZ);
    localparam logic [7:0] BLINK_HALF_1 = 8'(FR_NORM_HZ / 2);
    localparam logic [7:0] BLINK_HALF_2 = 8'(FR_NORM_HZ / 4);
    // ==========================================================
    // Serial receiver states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_CMD = 5'b00100,
        ST_DATA = 5'b01000,
        ST_SKIP = 5'b10000
    } lcdscu_state_t;
endpackage
`default_nettype wire

// ===== hdl/lcdscu_top.sv
// Serial command front end and scan logic of a 50x4 LCD segment driver.
// Assumes the serial pins, inhibit and external clock are asynchronous
// and that the pad ring resolves the open-drain data line.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Address 0x7C after start; then a command
// - Eight-bit bytes, each acknowledged
// - Ack low from eighth fall to ninth fall
// - Data line only pulled low, never high
// - Command top bit: command or data next
// - After data starts, commands need fresh start
// - Start or stop cancels partial command
// - Wrong address: no ack, ignore until start
// - RAM of fifty four-bit words
// - Data from set address, advance per nibble
// - Address wraps from 0x31 to zero
// - Nibble stored on receipt, not on ack
// - Clock source internal or external by command
// - Bias one-third or one-half by command
// - Line or frame inversion by command
// - Blink setting by command from frame clock
// - Soft reset: display off, address zero
// - Inhibit low forces display off
// - Four commons, fifty segments, quarter duty
// - Nominal frame rate eighty hertz
// - Address six bits, out of range gives zero
// - Display off blanks after one frame
// - Soft reset ignores other operation bits
module lcdscu_top #(
    parameter int P_SLOT_NORM = lcdscu_pkg::SLOT_NORM_CYC,
    parameter int P_SLOT_PS1 = lcdscu_pkg::SLOT_PS1_CYC,
    parameter int P_SLOT_PS2 = lcdscu_pkg::SLOT_PS2_CYC,
    parameter int P_SLOT_PS3 = lcdscu_pkg::SLOT_PS3_CYC
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Two-wire serial bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Pins
    input wire logic i_display_inhibit_n,
    input wire logic i_external_clock_pin,
    // Drive outputs
    output logic [lcdscu_pkg::NUM_COM-1:0] o_common_outputs,
    output logic [lcdscu_pkg::RAM_WORDS-1:0] o_segment_outputs,
    output logic o_polarity,
    // Settings seen by the analog side
    output logic o_bias_half,
    output logic o_frame_inv,
    output logic [1:0] o_frame_rate,
    output logic [1:0] o_sr_mode,
    output logic o_ext_clk_sel,
    output logic o_display_on
);
    import lcdscu_pkg::*;
    // ==========================================================
    // Elaboration check: slot counter is 20 bits wide
    if (P_SLOT_NORM < 2 || P_SLOT_PS3 > 1_000_000 || P_SLOT_PS1 < 2
        || P_SLOT_PS2 < 2 || P_SLOT_PS3 < 2) begin : g_bad_slot
        $error("lcdscu_top slot length out of range");
    end
    // ==========================================================
    // Synchronisers: first stage feeds only the second
    logic [1:0] scl_q, sda_q, inh_q, ext_q;
    logic scl_p, sda_p, ext_p; // Previous synced levels
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_q <= 2'h3;
            sda_q <= 2'h3;
            inh_q <= 2'h0;
            ext_q <= 2'h0;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            ext_p <= 1'b0;
        end else begin
            scl_q <= {scl_q[0], i_scl};
            sda_q <= {sda_q[0], i_sda};
            inh_q <= {inh_q[0], i_display_inhibit_n};
            ext_q <= {ext_q[0], i_external_clock_pin};
            scl_p <= scl_q[1];
            sda_p <= sda_q[1];
            ext_p <= ext_q[1];
        end
    end
    logic scl_rise, scl_fall, bus_start, bus_stop, ext_rise;
    assign scl_rise = scl_q[1] & ~scl_p;
    assign scl_fall = ~scl_q[1] & scl_p;
    assign bus_start = scl_q[1] & scl_p & sda_p & ~sda_q[1];
    assign bus_stop = scl_q[1] & scl_p & ~sda_p & sda_q[1];
    assign ext_rise = ext_q[1] & ~ext_p;
    // ==========================================================
    // Serial receiver
    lcdscu_state_t state_r;
    logic [3:0] bit_cnt_r; // Rising edges seen in this byte
    logic [6:0] shift_r;
    logic ack_pend_r; // Ack owed for the byte just taken
    logic drop_r; // A nibble of this byte found the FIFO full
    logic sda_oe_r;
    logic [7:0] rx_byte;
    logic byte_done, nib_evt, cmd_exec, push_ok, push_drop;
    logic fifo_in_ready;
    assign rx_byte = {shift_r, sda_q[1]};
    // Eighth rising edge completes a byte; bits taken MSB first
    assign byte_done = scl_rise && bit_cnt_r == 4'd7;
    // A command only acts once all eight bits are in
    assign cmd_exec = byte_done && state_r == ST_CMD;
    // Each nibble of a data byte is pushed when its last bit lands
    assign nib_evt = scl_rise && state_r == ST_DATA
        && (bit_cnt_r == 4'd3 || bit_cnt_r == 4'd7);
    assign push_ok = nib_evt & fifo_in_ready;
    assign push_drop = nib_evt & ~fifo_in_ready;
    // Byte framing and state; start/stop abandon partial bytes
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'd0;
            shift_r <= 7'h00;
            ack_pend_r <= 1'b0;
            drop_r <= 1'b0;
        end else if (bus_start) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'd0;
            ack_pend_r <= 1'b0;
            drop_r <= 1'b0;
        end else if (bus_stop) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'd0;
            ack_pend_r <= 1'b0;
        end else if (scl_rise && state_r != ST_IDLE) begin
            shift_r <= rx_byte[6:0];
            bit_cnt_r <= bit_cnt_r + 4'd1;
            if (push_drop) drop_r <= 1'b1;
            if (byte_done) begin
                case (state_r)
                    ST_ADDR: begin
                        // Wrong address: stay deaf until start
                        if (rx_byte == SLAVE_ADDR) begin
                            state_r <= ST_CMD;
                            ack_pend_r <= 1'b1;
                        end else begin
                            state_r <= ST_SKIP;
                            ack_pend_r <= 1'b0;
                        end
                    end
                    ST_CMD: begin
                        // Top bit picks command or data next
                        state_r <= rx_byte[CONT_BIT] ? ST_CMD : ST_DATA;
                        ack_pend_r <= 1'b1;
                    end
                    // Data state holds until the next start or stop
                    ST_DATA: ack_pend_r <= ~(drop_r | push_drop);
                    default: ack_pend_r <= 1'b0;
                endcase
            end
        end else if (scl_fall && bit_cnt_r == 4'd9) begin
            bit_cnt_r <= 4'd0;
            drop_r <= 1'b0;
        end
    end
    // ==========================================================
    // Acknowledge driver: low from eighth fall to ninth fall
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sda_oe_r <= 1'b0;
        end else if (bus_start || bus_stop) begin
            sda_oe_r <= 1'b0;
        end else if (scl_fall && bit_cnt_r == 4'd8) begin
            sda_oe_r <= ack_pend_r;
        end else if (scl_fall && bit_cnt_r == 4'd9) begin
            sda_oe_r <= 1'b0;
        end
    end
    // Open drain: the driven level is always low
    assign o_sda_o = 1'b0;
    assign o_sda_oe = sda_oe_r;
    // ==========================================================
    // Settings written by commands
    logic disp_on_r, bias_r, inv_r, ext_r, msb_r;
    logic [1:0] fr_r, sr_r, blink_r;
    logic soft_rst;
    assign soft_rst = cmd_exec && rx_byte[6:0] ==? PAT_OPERATION_CONFIG_CMD && rx_byte[IC_RST_BIT];
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            disp_on_r <= 1'b0;
            bias_r <= 1'b0;
            inv_r <= 1'b0;
            ext_r <= 1'b0;
            msb_r <= 1'b0;
            fr_r <= FR_RST;
            sr_r <= SR_RST;
            blink_r <= BLINK_RST;
        end else if (soft_rst) begin
            // Other operation bits are ignored on soft reset
            disp_on_r <= 1'b0;
            bias_r <= 1'b0;
            inv_r <= 1'b0;
            ext_r <= 1'b0;
            msb_r <= 1'b0;
            fr_r <= FR_RST;
            sr_r <= SR_RST;
            blink_r <= BLINK_RST;
        end else if (cmd_exec) begin
            case (1'b1)
                rx_byte[6:0] ==? PAT_MODE: begin
                    disp_on_r <= rx_byte[MODE_ON_BIT];
                    bias_r <= rx_byte[MODE_BIAS_BIT];
                end
                rx_byte[6:0] ==? PAT_DISPLAY_CONTROL_CMD: begin
                    fr_r <= rx_byte[DISC_FR_LSB +: 2];
                    inv_r <= rx_byte[DISC_WAVE_BIT];
                    sr_r <= rx_byte[DISC_SR_LSB +: 2];
                end
                rx_byte[6:0] ==? PAT_OPERATION_CONFIG_CMD: begin
                    msb_r <= rx_byte[IC_MSB_BIT];
                    ext_r <= rx_byte[IC_EXT_BIT];
                end
                rx_byte[6:0] ==? PAT_BLINK: blink_r <= rx_byte[BLINK_LSB +: 2];
                default: ;
            endcase
        end
    end
    // ==========================================================
    // Write address: set by command, advanced per nibble
    logic [5:0] wr_addr_r;
    logic [5:0] set_addr;
    assign set_addr = {msb_r, rx_byte[4:0]};
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_addr_r <= ADDR_RST;
        end else if (soft_rst) begin
            wr_addr_r <= ADDR_RST;
        end else if (cmd_exec && rx_byte[6:0] ==? PAT_ADDRESS_SET_CMD) begin
            // Out-of-range addresses fall back to zero
            wr_addr_r <= (set_addr > LAST_ADDR) ? ADDR_RST : set_addr;
        end else if (push_ok) begin
            // High nibble lands first, low nibble at the next word
            wr_addr_r <= (wr_addr_r == LAST_ADDR) ? ADDR_RST
                : wr_addr_r + 6'd1;
        end
    end
    // ==========================================================
    // Nibble FIFO between receiver and RAM; a full FIFO withholds ack
    logic [9:0] fifo_out;
    logic fifo_out_valid, ram_we, slot_tick;
    lcdscu_fifo #(.W(10), .D(8)) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_in_valid(nib_evt),
        .o_in_ready(fifo_in_ready),
        .i_in_data({wr_addr_r, rx_byte[3:0]}),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(~slot_tick),
        .o_out_data(fifo_out)
    );
    // RAM port yields to the scan on slot ticks
    assign ram_we = fifo_out_valid & ~slot_tick;
    // ==========================================================
    // Display RAM, untouched by soft reset
    logic [3:0] ram_r [RAM_WORDS];
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < RAM_WORDS; i++) ram_r[i] <= 4'h0;
        end else if (ram_we) begin
            ram_r[fifo_out[9:4]] <= fifo_out[3:0];
        end
    end
    // ==========================================================
    // Frame timing: internal divider or external pin edges
    logic [19:0] slot_cnt_r, slot_len;
    logic [1:0] com_idx_r;
    logic frame_end;
    always_comb begin
        case (fr_r)
            2'd0: slot_len = 20'(P_SLOT_NORM);
            2'd1: slot_len = 20'(P_SLOT_PS1);
            2'd2: slot_len = 20'(P_SLOT_PS2);
            default: slot_len = 20'(P_SLOT_PS3);
        endcase
    end
    // External mode takes one slot per pin rising edge
    assign slot_tick = ext_r ? ext_rise : (slot_cnt_r >= slot_len - 20'd1);
    assign frame_end = slot_tick && com_idx_r == 2'd3;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            slot_cnt_r <= 20'd0;
            com_idx_r <= 2'd0;
        end else if (slot_tick) begin
            slot_cnt_r <= 20'd0;
            com_idx_r <= com_idx_r + 2'd1;
        end else if (!ext_r) begin
            slot_cnt_r <= slot_cnt_r + 20'd1;
        end
    end
    // ==========================================================
    // Polarity, blanking and blink
    logic pol_r, blank_r, blink_ph_r, run;
    logic [7:0] blink_cnt_r, blink_half;
    assign run = disp_on_r & inh_q[1];
    always_comb begin
        case (blink_r)
            2'd1: blink_half = BLINK_HALF_05;
            2'd2: blink_half = BLINK_HALF_1;
            default: blink_half = BLINK_HALF_2;
        endcase
    end
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pol_r <= 1'b0;
        end else if (inv_r ? frame_end : slot_tick) begin
            pol_r <= ~pol_r;
        end
    end
    // Off keeps scanning for one frame of off data, then stops
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            blank_r <= 1'b1;
        end else if (run) begin
            blank_r <= 1'b0;
        end else if (frame_end) begin
            blank_r <= 1'b1;
        end
    end
    // Blink counts frames, so its rate follows the frame clock
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            blink_cnt_r <= 8'd0;
            blink_ph_r <= 1'b0;
        end else if (blink_r == BLINK_RST) begin
            blink_cnt_r <= 8'd0;
            blink_ph_r <= 1'b0;
        end else if (frame_end) begin
            if (blink_cnt_r >= blink_half - 8'd1) begin
                blink_cnt_r <= 8'd0;
                blink_ph_r <= ~blink_ph_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 8'd1;
            end
        end
    end
    // ==========================================================
    // Drive outputs, registered every cycle
    logic [RAM_WORDS-1:0] seg_nxt;
    logic [NUM_COM-1:0] com_r;
    logic [RAM_WORDS-1:0] seg_r;
    logic show;
    assign show = run & ~blink_ph_r;
    for (genvar g = 0; g < RAM_WORDS; g++) begin : g_seg
        // Bit 3 of a word belongs to the first common
        assign seg_nxt[g] = (ram_r[g][~com_idx_r] & show) ^ pol_r;
    end
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            com_r <= '0;
            seg_r <= '0;
        end else if (blank_r) begin
            com_r <= '0;
            seg_r <= '0;
        end else begin
            com_r <= NUM_COM'(1) << com_idx_r;
            seg_r <= seg_nxt;
        end
    end
    assign o_common_outputs = com_r;
    assign o_segment_outputs = seg_r;
    assign o_polarity = pol_r;
    assign o_bias_half = bias_r;
    assign o_frame_inv = inv_r;
    assign o_frame_rate = fr_r;
    assign o_sr_mode = sr_r;
    assign o_ext_clk_sel = ext_r;
    assign o_display_on = disp_on_r;
    // ==========================================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    sequence ack_open_s;
        scl_fall && bit_cnt_r == 4'd8 && ack_pend_r && !bus_start && !bus_stop;
    endsequence
    sequence ack_close_s;
        scl_fall && bit_cnt_r == 4'd9 && !bus_start && !bus_stop;
    endsequence
    ack_open_a: assert property (ack_open_s |=> o_sda_oe)
        else $error("ack not driven after eighth fall");
    ack_close_a: assert property (ack_close_s |=> !o_sda_oe)
        else $error("ack not released after ninth fall");
    drive_low_a: assert property (o_sda_oe |-> !o_sda_o && $past(bit_cnt_r) >= 4'd8)
        else $error("data line driven outside ack or high");
    bad_addr_a: assert property (byte_done && state_r == ST_ADDR
        && rx_byte != SLAVE_ADDR && !bus_start && !bus_stop |=> state_r == ST_SKIP)
        else $error("foreign address not ignored");
    data_hold_a: assert property (state_r == ST_DATA && !bus_start
        && !bus_stop |=> state_r == ST_DATA)
        else $error("data state left without start or stop");
    addr_wrap_a: assert property (push_ok && !soft_rst && wr_addr_r == LAST_ADDR
        |=> wr_addr_r == ADDR_RST)
        else $error("write address did not wrap");
    soft_rst_a: assert property (soft_rst |=> !disp_on_r && wr_addr_r == ADDR_RST
        && !ext_r)
        else $error("soft reset left state behind");
    blank_off_a: assert property (!run && frame_end ##1 !run |=> o_common_outputs == '0)
        else $error("outputs not blanked a frame after off");
endmodule
`default_nettype wire

// ===== tb/lcd_segment_serial_command_unit_tb_top.sv
// Bench: drives the unit through the host model and checks settings.
// Assumes shortened slot lengths; pins move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_serial_command_unit_tb_top;
    import lcdscu_pkg::*;
    // ========
    // Clock, reset, pins and outputs
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic scl, sda_low, sda_oe, sda_o, ack;
    logic bias_half, frame_inv, ext_sel, disp_on;
    logic [1:0] frame_rate, sr_mode;
    logic inh_n = 1'b1;
    logic pol;
    logic [NUM_COM-1:0] com;
    logic [RAM_WORDS-1:0] seg;
    int n_errors = 0;
    int samples_checked = 0;
    wire sda;
    // Pull-up wins unless someone pulls low
    assign sda = ~(sda_low | (sda_oe & ~sda_o));
    initial forever #2.5 i_ref_clk = ~i_ref_clk;
    lcdscu_top #(.P_SLOT_NORM(8), .P_SLOT_PS1(9), .P_SLOT_PS2(10), .P_SLOT_PS3(12)) u_dut (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_display_inhibit_n(inh_n),
        .i_external_clock_pin(1'b0), .o_common_outputs(com), .o_segment_outputs(seg),
        .o_polarity(pol), .o_bias_half(bias_half), .o_frame_inv(frame_inv),
        .o_frame_rate(frame_rate), .o_sr_mode(sr_mode), .o_ext_clk_sel(ext_sel),
        .o_display_on(disp_on));
    lcdscu_host u_host (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
    // ========
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic t_cmds();
        u_host.start();
        u_host.send(SLAVE_ADDR, 8, ack);
        chk(ack, 1'b1);
        u_host.send(8'hCC, 8, ack);
        chk(ack, 1'b1);
        u_host.send(8'h3D, 8, ack);
        u_host.send(8'hA5, 8, ack);
        chk(ack, 1'b1);
        u_host.send(8'hE9, 8, ack);
        u_host.stop();
        chk({disp_on, bias_half}, 2'h3);
        chk({frame_inv, frame_rate, sr_mode}, 5'h1D);
        chk({ext_sel, sda_oe}, 2'h0);
        $display("Test commands then data done");
    endtask
    // Word 0x31 then wrap to word 0; then scan and inhibit
    task automatic t_drive();
        u_host.start();
        u_host.send(SLAVE_ADDR, 8, ack);
        u_host.send(8'hEC, 8, ack);
        u_host.send(8'h11, 8, ack);
        u_host.send(8'h87, 8, ack);
        chk(ack, 1'b1);
        u_host.stop();
        for (int i = 0; i < 100 && com !== 4'h1; i++) @(negedge i_ref_clk);
        chk(com, 4'h1);
        chk({seg[49], seg[3:0]}, {5{pol}} ^ 5'h1C);
        chk(seg[48:4] == {45{pol}}, 1'b1);
        inh_n = 1'b0;
        repeat (80) @(negedge i_ref_clk);
        chk({com, seg[0]}, 5'h0);
        inh_n = 1'b1;
        $display("Test wrap and drive done");
    endtask
    task automatic t_refused();
        u_host.start();
        u_host.send(8'h7E, 8, ack);
        chk(ack, 1'b0);
        u_host.send(8'hE9, 8, ack);
        chk(ack, 1'b0);
        u_host.stop();
        u_host.start();
        u_host.send(SLAVE_ADDR, 8, ack);
        u_host.send(8'hE9, 4, ack);
        u_host.stop();
        chk(ext_sel, 1'b0);
        $display("Test refused traffic done");
    endtask
    task automatic t_soft();
        u_host.start();
        u_host.send(SLAVE_ADDR, 8, ack);
        u_host.send(8'hE9, 9, ack);
        chk(ext_sel, 1'b1);
        u_host.send(8'h6A, 8, ack);
        chk(ack, 1'b1);
        u_host.stop();
        chk({disp_on, bias_half, frame_inv, ext_sel}, 4'h0);
        chk({frame_rate, sr_mode}, {FR_RST, SR_RST});
        $display("Test soft reset done");
    endtask
    task automatic report_and_stop();
        $display("Checked %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge i_ref_clk);
        i_rstn = 1'b1;
        repeat (8) @(negedge i_ref_clk);
        chk({disp_on, sr_mode}, {1'b0, SR_RST});
        t_cmds();
        t_drive();
        t_refused();
        t_soft();
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== tb/lcdscu_host.sv
// Host model: two-wire bus master; data line has a pull-up.
// Assumes the bench clock paces it; pins move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module lcdscu_host (
    // Pacing clock and resolved data line
    input wire logic i_ref_clk,
    input wire logic i_sda,
    // Host pins
    output logic o_scl,
    output logic o_sda_low
);
    // ========
    // Idle bus: both lines high
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Ten clocks per phase, well above the minimum of four
    task automatic hp();
        repeat (10) @(negedge i_ref_clk);
    endtask
    // Data falls while clock high, then clock low
    task automatic start();
        o_sda_low = 1'b1;
        hp();
        o_scl = 1'b0;
        hp();
    endtask
    // Data rises while clock high
    task automatic stop();
        o_sda_low = 1'b1;
        hp();
        o_scl = 1'b1;
        hp();
        o_sda_low = 1'b0;
        hp();
    endtask
    // MSB first; a whole byte gets a ninth clock with the line released.
    // With n of 9 the host ignores ack and holds the line low itself.
    task automatic send(input logic [7:0] b, input int n, output logic ack);
        ack = 1'b0;
        for (int i = 7; i > 7 - n && i >= 0; i--) begin
            o_sda_low = ~b[i];
            hp();
            o_scl = 1'b1;
            hp();
            o_scl = 1'b0;
        end
        o_sda_low = (n > 8);
        if (n >= 8) begin
            hp();
            o_scl = 1'b1;
            hp();
            ack = ~i_sda;
            o_scl = 1'b0;
        end
        hp();
    endtask
endmodule
`default_nettype wire
